/* File: hdl/radio_ctrl_defines.svh */
// Constants for the retransmission and radio control block.
// Assumes a 200 MHz aclk and AXI4-Lite word access (byte address = 4 x index).
`ifndef RADIO_CTRL_DEFINES_SVH
`define RADIO_CTRL_DEFINES_SVH
// Register indices (byte address is four times the index)
`define IDX_PORT0_SRC     14'h009B
`define IDX_DATA_RATE     14'h220B
`define IDX_RETRY_COUNT   14'h220C
`define IDX_RETRY_ACK     14'h220D
`define IDX_TX_RAMP       14'h221A
`define IDX_TX_POWER      14'h221B
`define IDX_MONITOR       14'h2253
`define IDX_INT_CTRL      14'h225D
`define IDX_CHAN_FREQ     14'h2276
`define IDX_MODEM_CTRL    14'h2280
`define IDX_MODEM_STATUS  14'h2281
`define IDX_PORT1_SRC     14'h2282
// Reset values
`define RST_PORT0_SRC     8'h00
`define RST_DATA_RATE     8'h04
`define RST_RETRY_COUNT   8'h10
`define RST_RETRY_ACK     8'hCA
`define RST_TX_RAMP       8'h00
`define RST_TX_POWER      8'h17
`define RST_MONITOR       8'h14
`define RST_INT_CTRL      8'h00
`define RST_CHAN_FREQ     8'h33
`define RST_PORT1_SRC     8'h00
// Write masks for fields with read-only zero bits
`define MASK_TX_POWER     8'h1F
`define MASK_CHAN_FREQ    8'h7F
// Field positions
`define F_IRQ_SEL         4
`define F_ACK_IND         7
`define F_ACK_EN          4
`define F_MODEM_ON        0
`define F_CAL_START       1
`define F_SW_P0           5
`define F_SWN_P0          4
`define F_SW_P1           1
`define F_SWN_P1          0
// Monitor code that routes the switch pair to the port pins
`define MON_SWITCH_CODE   8'h99
// Ack wait unit and clock rate
`define ACK_UNIT_US       128
`define CLK_MHZ           200
// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

/* File: hdl/radio_ctrl_pkg.sv */
// Types shared by the retransmission and radio control block.
// Assumes nothing beyond a SystemVerilog compiler.
package radio_ctrl_pkg;
	// Modem state machine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX_CAL,
		ST_PLL_SETTLE,
		ST_TX_PKT,
		ST_ACK_WAIT,
		ST_RX_WAIT,
		ST_RX_PKT
	} state_t;
endpackage

/* File: hdl/tx_retransmit_radio_ctrl.sv */
// Modem control: automatic retransmission, channel and power registers,
// transmit/receive switch routing, and the first modem states.
// Assumes MAC and radio datapath strobes come from logic on aclk.
`timescale 1ns/1ps
`default_nettype none
`include "radio_ctrl_defines.svh"

// Notes on behaviour
// - No-ack frames resend in burst, receiver off
// - Ack mode waits for ack, resends same frame
// - Ack or retry limit ends retransmission immediately
// - Retry field zero: single send; N: N retries
// - Interrupt select: every send or last only
// - Ack mode needs indication and enable both set
// - Ack wait is field times 128 us
// - Configuration registers keep contents through power-down
// - Channel field gives 2394 MHz plus value
// - Power field 5 bits, resets 0x17, upper zero
// - Switch output high while transmitting
// - Switch pair shareable on port 1 bits 7,6
// - Port 0 source select maps pins to baseband
// - Monitor code 0x99 routes pair to port 0
// - Reset enters idle, no operation there
// - Transmit only with frame ready, else receive
// - Calibration start enters RX cal, returns idle
// - Transmit end returns to PLL settle, interrupt
// - Receive end returns to RX wait, interrupt
module tx_retransmit_radio_ctrl
	import radio_ctrl_pkg::*;
#(
	parameter int ACK_UNIT_CYC = `ACK_UNIT_US * `CLK_MHZ
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        tx_frame_ready,
	input  wire logic        tx_ack_req,
	input  wire logic        phy_tx_done,
	input  wire logic        rx_ack_rcvd,
	input  wire logic        rx_pkt_detect,
	input  wire logic        rx_pkt_end,
	input  wire logic        pll_locked,
	input  wire logic        cal_done,
	output logic             tx_start,
	output logic             tx_frame_done,
	output logic             rx_enable,
	output logic             cal_active,
	output logic             tx_end_irq,
	output logic             rx_end_irq,
	output logic [6:0]       channel_offset_mhz,
	output logic [4:0]       tx_power_select,
	output logic [2:0]       data_rate_select,
	output logic             tr_switch_out,
	output logic             tr_switch_out_n,
	output logic [7:0]       port0_bb_en,
	output logic [7:0]       port0_bb_out,
	output logic [1:0]       port1_bb_en,
	output logic [1:0]       port1_bb_out
);
	// Configuration registers; only aresetn clears them, apart from the self-clearing calibration start bit, so they survive power-down
	logic [7:0]  port0_src_ff, data_rate_ff, retry_cnt_cfg_ff, retry_ack_ff;
	logic [7:0]  tx_ramp_ff, tx_power_ff, monitor_ff, int_ctrl_ff;
	logic [7:0]  chan_freq_ff, modem_ctrl_ff, port1_src_ff;
	state_t      state_ff, nxt_state;      // Modem state
	logic [3:0]  retry_cnt_ff;             // Resends done for this frame
	logic [31:0] unit_cnt_ff;              // Cycles inside one 128 us unit
	logic [3:0]  unit_tally_ff;            // Whole units elapsed in ack wait
	logic        aw_go, ar_go;             // Requests taken this cycle; handshake next cycle
	logic [13:0] wr_idx, rd_idx;
	logic        wr_hit;                   // Write address decoded
	logic [7:0]  rd_val;
	logic        rd_hit;
	logic        ack_mode, retries_left, ack_timeout, sw_route;

	// Ack mode needs both indication and enable, plus the frame's request
	assign ack_mode = retry_ack_ff[`F_ACK_IND] & retry_ack_ff[`F_ACK_EN] & tx_ack_req;
	assign retries_left = (retry_cnt_ff < retry_cnt_cfg_ff[3:0]);
	// Wait of N units; N of zero expires at once
	assign ack_timeout = (unit_tally_ff >= retry_ack_ff[3:0]);

	// Write handshake: address and data taken together, one at a time
	assign aw_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
	assign ar_go  = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
	assign wr_idx = s_axi_awaddr[15:2];
	assign rd_idx = s_axi_araddr[15:2];

	// Write address decode
	always_comb begin
		case (wr_idx)
			`IDX_PORT0_SRC, `IDX_DATA_RATE, `IDX_RETRY_COUNT, `IDX_RETRY_ACK,
			`IDX_TX_RAMP, `IDX_TX_POWER, `IDX_MONITOR, `IDX_INT_CTRL,
			`IDX_CHAN_FREQ, `IDX_MODEM_CTRL, `IDX_MODEM_STATUS,
			`IDX_PORT1_SRC: wr_hit = 1'b1;
			default:        wr_hit = 1'b0;
		endcase
	end

	// Read mux; status shows live state and retry count
	always_comb begin
		rd_hit = 1'b1;
		case (rd_idx)
			`IDX_PORT0_SRC:    rd_val = port0_src_ff;
			`IDX_DATA_RATE:    rd_val = data_rate_ff;
			`IDX_RETRY_COUNT:  rd_val = retry_cnt_cfg_ff;
			`IDX_RETRY_ACK:    rd_val = retry_ack_ff;
			`IDX_TX_RAMP:      rd_val = tx_ramp_ff;
			`IDX_TX_POWER:     rd_val = tx_power_ff;
			`IDX_MONITOR:      rd_val = monitor_ff;
			`IDX_INT_CTRL:     rd_val = int_ctrl_ff;
			`IDX_CHAN_FREQ:    rd_val = chan_freq_ff;
			`IDX_MODEM_CTRL:   rd_val = modem_ctrl_ff;
			`IDX_MODEM_STATUS: rd_val = {1'b0, state_ff, retry_cnt_ff};
			`IDX_PORT1_SRC:    rd_val = port1_src_ff;
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Bus channel flops; unmapped addresses answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
		end else begin
			s_axi_awready <= aw_go;
			s_axi_wready  <= aw_go;
			// Response waits for the ready edge, so it never leads the handshake
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ar_go;
			// Read data follows the address handshake by one cycle
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h00_0000, rd_val};
				s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Register writes, low byte lane only; calibration start self-clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port0_src_ff     <= `RST_PORT0_SRC;
			data_rate_ff     <= `RST_DATA_RATE;
			retry_cnt_cfg_ff <= `RST_RETRY_COUNT;
			retry_ack_ff     <= `RST_RETRY_ACK;
			tx_ramp_ff       <= `RST_TX_RAMP;
			tx_power_ff      <= `RST_TX_POWER;
			monitor_ff       <= `RST_MONITOR;
			int_ctrl_ff      <= `RST_INT_CTRL;
			chan_freq_ff     <= `RST_CHAN_FREQ;
			modem_ctrl_ff    <= 8'h00;
			port1_src_ff     <= `RST_PORT1_SRC;
		end else begin
			// Start bit is a command: dropped once the FSM has taken it
			if (state_ff == ST_RX_CAL)
				modem_ctrl_ff[`F_CAL_START] <= 1'b0;
			if (aw_go && s_axi_wstrb[0]) begin
				case (wr_idx)
					`IDX_PORT0_SRC:   port0_src_ff     <= s_axi_wdata[7:0];
					`IDX_DATA_RATE:   data_rate_ff     <= s_axi_wdata[7:0];
					`IDX_RETRY_COUNT: retry_cnt_cfg_ff <= s_axi_wdata[7:0];
					`IDX_RETRY_ACK:   retry_ack_ff     <= s_axi_wdata[7:0];
					`IDX_TX_RAMP:     tx_ramp_ff       <= s_axi_wdata[7:0];
					`IDX_TX_POWER:    tx_power_ff <= s_axi_wdata[7:0] & `MASK_TX_POWER;
					`IDX_MONITOR:     monitor_ff       <= s_axi_wdata[7:0];
					`IDX_INT_CTRL:    int_ctrl_ff      <= s_axi_wdata[7:0];
					// Non 5N+1 values are accepted as written; software keeps to the grid
					`IDX_CHAN_FREQ:   chan_freq_ff <= s_axi_wdata[7:0] & `MASK_CHAN_FREQ;
					`IDX_MODEM_CTRL:  modem_ctrl_ff    <= s_axi_wdata[7:0];
					`IDX_PORT1_SRC:   port1_src_ff     <= s_axi_wdata[7:0];
					default:          ;
				endcase
			end
		end
	end

	// Modem state machine next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				// Idle does nothing until software asks                       
				if (modem_ctrl_ff[`F_CAL_START])
					nxt_state = ST_RX_CAL;
				else if (modem_ctrl_ff[`F_MODEM_ON])
					nxt_state = ST_PLL_SETTLE;
			end
			ST_RX_CAL: begin
				if (cal_done)
					nxt_state = ST_IDLE;
			end
			ST_PLL_SETTLE: begin
				if (!modem_ctrl_ff[`F_MODEM_ON])
					nxt_state = ST_IDLE;
				else if (pll_locked)
					nxt_state = tx_frame_ready ? ST_TX_PKT : ST_RX_WAIT;
			end
			ST_TX_PKT: begin
				if (phy_tx_done) begin
					if (ack_mode)
						nxt_state = ST_ACK_WAIT;
					else if (!retries_left)
						nxt_state = ST_PLL_SETTLE;
				end
			end
			ST_ACK_WAIT: begin
				if (rx_ack_rcvd)
					nxt_state = ST_PLL_SETTLE;
				else if (ack_timeout)
					nxt_state = retries_left ? ST_TX_PKT : ST_PLL_SETTLE;
			end
			ST_RX_WAIT: begin
				if (!modem_ctrl_ff[`F_MODEM_ON])
					nxt_state = ST_IDLE;
				else if (tx_frame_ready)
					nxt_state = ST_PLL_SETTLE;
				else if (rx_pkt_detect)
					nxt_state = ST_RX_PKT;
			end
			ST_RX_PKT: begin
				if (rx_pkt_end)
					nxt_state = ST_RX_WAIT;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// State register; reset lands in idle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Retry counter: cleared on a new frame, bumped per automatic resend
	always_ff @(posedge aclk) begin
		if (!aresetn)
			retry_cnt_ff <= 4'h0;
		else if (state_ff == ST_PLL_SETTLE)
			retry_cnt_ff <= 4'h0;
		else if (state_ff == ST_TX_PKT && phy_tx_done && !ack_mode && retries_left)
			retry_cnt_ff <= retry_cnt_ff + 4'h1;
		else if (state_ff == ST_ACK_WAIT && !rx_ack_rcvd && ack_timeout && retries_left)
			retry_cnt_ff <= retry_cnt_ff + 4'h1;
	end

	// Ack wait timer: restarts whenever the FSM is not waiting, so each send end in ack mode starts it
	always_ff @(posedge aclk) begin
		if (!aresetn || state_ff != ST_ACK_WAIT) begin
			unit_cnt_ff   <= 32'h0000_0000;
			unit_tally_ff <= 4'h0;
		end else if (unit_cnt_ff == 32'(ACK_UNIT_CYC - 1)) begin
			unit_cnt_ff   <= 32'h0000_0000;
			unit_tally_ff <= unit_tally_ff + 4'h1;
		end else begin
			unit_cnt_ff <= unit_cnt_ff + 32'h0000_0001;
		end
	end

	// Datapath strobes and interrupts, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_start      <= 1'b0;
			tx_frame_done <= 1'b0;
			tx_end_irq    <= 1'b0;
			rx_end_irq    <= 1'b0;
		end else begin
			// Start fires on every entry into the transmit state, first send or resend
			tx_start      <= (nxt_state == ST_TX_PKT) &&
			                 (state_ff != ST_TX_PKT || phy_tx_done);
			tx_frame_done <= (state_ff != ST_PLL_SETTLE) && (nxt_state == ST_PLL_SETTLE) &&
			                 (state_ff == ST_TX_PKT || state_ff == ST_ACK_WAIT);
			// Last-only mode holds the interrupt until the frame is finished;
			// in ack mode the last send is only known when the wait ends
			tx_end_irq    <= ((state_ff == ST_TX_PKT) && phy_tx_done &&
			                  (retry_cnt_cfg_ff[`F_IRQ_SEL] ||
			                   (!ack_mode && !retries_left))) ||
			                 ((state_ff == ST_ACK_WAIT) && (nxt_state == ST_PLL_SETTLE) &&
			                  !retry_cnt_cfg_ff[`F_IRQ_SEL]);
			rx_end_irq    <= (state_ff == ST_RX_PKT) && rx_pkt_end;
		end
	end

	// Radio enables and the switch pair; receiver stays off through burst sends
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_enable       <= 1'b0;
			cal_active      <= 1'b0;
			tr_switch_out   <= 1'b0;
			tr_switch_out_n <= 1'b1;
		end else begin
			rx_enable       <= (state_ff == ST_RX_WAIT) || (state_ff == ST_RX_PKT) ||
			                   (state_ff == ST_ACK_WAIT);
			cal_active      <= (state_ff == ST_RX_CAL);
			tr_switch_out   <= (state_ff == ST_TX_PKT);
			tr_switch_out_n <= (state_ff != ST_TX_PKT);
		end
	end

	// Monitor code gates the switch pair onto the port pins
	assign sw_route = (monitor_ff == `MON_SWITCH_CODE);

	// Pin routing; both ports drive the pair only when selected and routed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port0_bb_en  <= 8'h00;
			port0_bb_out <= 8'h00;
			port1_bb_en  <= 2'h0;
			port1_bb_out <= 2'h0;
		end else begin
			port0_bb_en  <= port0_src_ff;
			port0_bb_out <= 8'h00;
			// Same timing as tr_switch_out, so pins and switch agree while the monitor code routes the pair
			port0_bb_out[`F_SW_P0]  <= sw_route & (state_ff == ST_TX_PKT);
			port0_bb_out[`F_SWN_P0] <= sw_route & (state_ff != ST_TX_PKT);
			port1_bb_en  <= port1_src_ff[7:6];
			port1_bb_out[`F_SW_P1]  <= sw_route & (state_ff == ST_TX_PKT);
			port1_bb_out[`F_SWN_P1] <= sw_route & (state_ff != ST_TX_PKT);
		end
	end

	// Configuration fields to the radio
	assign channel_offset_mhz = chan_freq_ff[6:0];
	assign tx_power_select    = tx_power_ff[4:0];
	assign data_rate_select   = data_rate_ff[2:0];

	a_burst_no_rx: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == ST_TX_PKT) |=> !rx_enable)
		else $error("receiver enabled during transmit");
	a_ack_resend: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == ST_TX_PKT && phy_tx_done && ack_mode) |=> (state_ff == ST_ACK_WAIT))
		else $error("ack wait not entered");
	a_ack_stops: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == ST_ACK_WAIT && rx_ack_rcvd) |=> (state_ff == ST_PLL_SETTLE) ##0 tx_frame_done)
		else $error("ack did not end retransmission");
	a_timeout_send: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == ST_ACK_WAIT && !rx_ack_rcvd && ack_timeout && retries_left)
		|=> (state_ff == ST_TX_PKT) && tx_start && (retry_cnt_ff == $past(retry_cnt_ff) + 4'h1))
		else $error("timeout did not resend");
	a_idle_reset: assert property (@(posedge aclk)
		$rose(aresetn) |-> (state_ff == ST_IDLE))
		else $error("not idle after reset");
	a_cal_return: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == ST_RX_CAL && cal_done) |=> (state_ff == ST_IDLE) ##1 !cal_active)
		else $error("calibration did not return to idle");
	a_switch_tx: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == ST_TX_PKT) |=> tr_switch_out)
		else $error("switch low while transmitting");
	a_switch_inv: assert property (@(posedge aclk) disable iff (!aresetn)
		tr_switch_out_n == !tr_switch_out)
		else $error("switch pair not complementary");
	a_rx_end: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == ST_RX_PKT && rx_pkt_end) |=> rx_end_irq && (state_ff == ST_RX_WAIT))
		else $error("receive end not signalled");
	a_power_top: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_power_ff[7:5] == 3'h0)
		else $error("power upper bits set");
	a_last_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == ST_TX_PKT && phy_tx_done && !retry_cnt_cfg_ff[`F_IRQ_SEL] && retries_left)
		|=> !tx_end_irq)
		else $error("interrupt before last send");
	a_tx_done_pll: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == ST_TX_PKT && phy_tx_done && !ack_mode && !retries_left)
		|=> (state_ff == ST_PLL_SETTLE) && tx_end_irq)
		else $error("transmit end mishandled");
endmodule
`default_nettype wire

/* File: test/radio_far_model.sv */
// Far side: MAC transmit FIFO holding one frame, and the remote radio.
// Assumes strobes on aclk; the synthesizer is always reported locked.
`timescale 1ns/1ps
`default_nettype none
module radio_far_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       frame_go,
	input  wire logic       frame_ack,
	input  wire logic [3:0] ack_at,
	input  wire logic       tx_start,
	input  wire logic       tx_frame_done,
	input  wire logic       cal_active,
	output logic            tx_frame_ready,
	output logic            tx_ack_req,
	output logic            phy_tx_done,
	output logic            rx_ack_rcvd,
	output logic            cal_done,
	output logic            pll_locked
);
	logic [2:0] air_ff;  // Air time left of the current send
	logic [1:0] ack_ff;  // Delay until the remote ack lands
	logic [3:0] sends_ff; // Sends of this frame; ack_at of zero matches only a 16th send
	logic [1:0] cal_ff;  // Calibration run time
	logic       pend_ff; // Frame held in the FIFO
	assign pll_locked = 1'b1;
	// FIFO lets go as soon as done shows: the block samples ready again in
	// the very next settle cycle and would otherwise resend a stale frame
	assign tx_frame_ready = pend_ff & ~tx_frame_done;
	// Frame stays queued until the block reports it finished
	always_ff @(posedge aclk) begin
		if (!aresetn || tx_frame_done) begin
			pend_ff    <= 1'b0;
			tx_ack_req <= 1'b0;
		end else if (frame_go) begin
			pend_ff    <= 1'b1;
			tx_ack_req <= frame_ack;
		end
	end
	// Each send occupies the air for four cycles
	always_ff @(posedge aclk) begin
		phy_tx_done <= 1'b0;
		if (!aresetn) begin
			air_ff <= 3'h0;
		end else if (tx_start) begin
			air_ff <= 3'h4;
		end else if (air_ff != 3'h0) begin
			air_ff      <= air_ff - 3'h1;
			phy_tx_done <= (air_ff == 3'h1);
		end
	end
	// Remote node answers only the chosen send
	always_ff @(posedge aclk) begin
		rx_ack_rcvd <= 1'b0;
		if (!aresetn || frame_go) begin
			sends_ff <= 4'h0;
			ack_ff   <= 2'h0;
		end else begin
			if (tx_start) begin
				sends_ff <= sends_ff + 4'h1;
			end
			if (phy_tx_done && tx_ack_req && sends_ff == ack_at) begin
				ack_ff <= 2'h2;
			end else if (ack_ff != 2'h0) begin
				ack_ff      <= ack_ff - 2'h1;
				rx_ack_rcvd <= (ack_ff == 2'h1);
			end
		end
	end
	// One completion pulse per calibration episode
	always_ff @(posedge aclk) begin
		if (!aresetn || !cal_active) begin
			cal_ff <= 2'h0;
		end else if (cal_ff != 2'h3) begin
			cal_ff <= cal_ff + 2'h1;
		end
		cal_done <= aresetn && cal_active && cal_ff == 2'h2;
	end
endmodule
`default_nettype wire

/* File: test/test_tx_retransmit_radio_ctrl.sv */
// Testbench: registers over AXI4-Lite, frames through the far-side model.
// Assumes a 4-cycle ack unit and one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "radio_ctrl_defines.svh"
module test_tx_retransmit_radio_ctrl;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic tx_frame_ready, tx_ack_req, phy_tx_done, rx_ack_rcvd, rx_pkt_detect, rx_pkt_end;
	logic pll_locked, cal_done, tx_start, tx_frame_done, rx_enable, cal_active;
	logic tx_end_irq, rx_end_irq, tr_switch_out, tr_switch_out_n, frame_go, frame_ack;
	logic [1:0]  s_axi_bresp, s_axi_rresp, port1_bb_en, port1_bb_out, resp;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0]  s_axi_wstrb, ack_at;
	logic [6:0]  channel_offset_mhz;
	logic [4:0]  tx_power_select;
	logic [2:0]  data_rate_select;
	logic [7:0]  port0_bb_en, port0_bb_out;
	int          n_fail, n_tests, i;
	tx_retransmit_radio_ctrl #(.ACK_UNIT_CYC(4)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_frame_ready, .tx_ack_req,
		.phy_tx_done, .rx_ack_rcvd, .rx_pkt_detect, .rx_pkt_end, .pll_locked, .cal_done,
		.tx_start, .tx_frame_done, .rx_enable, .cal_active, .tx_end_irq, .rx_end_irq,
		.channel_offset_mhz, .tx_power_select, .data_rate_select, .tr_switch_out,
		.tr_switch_out_n, .port0_bb_en, .port0_bb_out, .port1_bb_en, .port1_bb_out);
	radio_far_model i_far (.aclk, .aresetn, .frame_go, .frame_ack, .ack_at, .tx_start,
		.tx_frame_done, .cal_active, .tx_frame_ready, .tx_ack_req, .phy_tx_done,
		.rx_ack_rcvd, .cal_done, .pll_locked);
	initial aclk = 1'b0;
	always #2.5 aclk = ~aclk;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic hang(input string what);
		chk(what, 32'h1, 32'h0);
		end_of_test();
	endtask
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		int t;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (t == 50) hang("write answer");
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [13:0] idx);
		int t;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (t == 50) hang("read answer");
		rd_data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Bounded wait for a level; running out ends the run
	task automatic wait_lvl(ref logic s, input logic v, input string what);
		int t;
		for (t = 0; t < 200; t++) begin
			@(posedge aclk);
			if (s === v) break;
		end
		if (t == 200) hang(what);
	endtask
	// One frame: count sends and end interrupts, watch receiver and pins
	task automatic run_frame(input logic ack, input logic [3:0] at, input logic burst,
		input logic [31:0] n_start, input logic [31:0] n_irq, input string what);
		int t, starts, irqs, bad, sw;
		starts = 0;
		irqs = 0;
		bad = 0;
		sw = 0;
		@(posedge aclk);
		frame_ack <= ack;
		ack_at <= at;
		frame_go <= 1'b1;
		@(posedge aclk);
		frame_go <= 1'b0;
		for (t = 0; t < 400; t++) begin
			@(posedge aclk);
			if (tx_start === 1'b1) starts++;
			if (tx_end_irq === 1'b1) irqs++;
			if (tr_switch_out === 1'b1) sw++;
			// Receiver must stay off for the whole burst
			if (burst && starts > 0 && rx_enable !== 1'b0) bad++;
			if (tr_switch_out_n !== ~tr_switch_out) bad++;
			if (port0_bb_out[5:4] !== {tr_switch_out, tr_switch_out_n}) bad++;
			if (port1_bb_out !== {tr_switch_out, tr_switch_out_n}) bad++;
			if (tx_frame_done === 1'b1) break;
		end
		if (t == 400) hang(what);
		chk({what, " sends"}, n_start, starts);
		chk({what, " end irqs"}, n_irq, irqs);
		chk({what, " pin faults"}, 32'h0, bad);
		chk({what, " switch on"}, 32'h1, 32'(sw > 0));
	endtask
	logic [13:0] ridx [6] = '{`IDX_RETRY_COUNT, `IDX_RETRY_ACK, `IDX_TX_POWER, `IDX_MONITOR,
		`IDX_CHAN_FREQ, `IDX_PORT0_SRC};
	logic [7:0]  rval [6] = '{8'h10, 8'hCA, 8'h17, 8'h14, 8'h33, 8'h00};
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{rx_pkt_detect, rx_pkt_end, frame_go, frame_ack, ack_at} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		n_fail = 0;
		n_tests = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 6; i++) begin
			rd(ridx[i]);
			chk("reset value", {24'h0, rval[i]}, rd_data);
		end
		rd(`IDX_MODEM_STATUS);
		chk("idle status", 32'h0, rd_data);
		rd(14'h0100);
		chk("unmapped read", 32'h2, 32'(resp));
		wr(14'h0101, 8'h55);
		chk("unmapped write", 32'h2, 32'(resp));
		wr(`IDX_TX_POWER, 8'hFF);
		rd(`IDX_TX_POWER);
		chk("power field", 32'h1F, rd_data);
		chk("power out", 32'h1F, 32'(tx_power_select));
		wr(`IDX_CHAN_FREQ, 8'h10);
		chk("channel out", 32'h10, 32'(channel_offset_mhz));
		wr(`IDX_MODEM_CTRL, 8'h02);
		wait_lvl(cal_active, 1'b1, "cal start");
		wait_lvl(cal_active, 1'b0, "cal end");
		rd(`IDX_MODEM_STATUS);
		chk("back to idle", 32'h0, rd_data);
		wr(`IDX_PORT0_SRC, 8'h30);
		wr(`IDX_MONITOR, 8'h99);
		wr(`IDX_PORT1_SRC, 8'hC0);
		chk("port0 enables", 32'h30, 32'(port0_bb_en));
		chk("port1 enables", 32'h3, 32'(port1_bb_en));
		chk("port0 idle pins", 32'h10, 32'(port0_bb_out));
		wr(`IDX_MODEM_CTRL, 8'h01);
		wait_lvl(rx_enable, 1'b1, "receive mode");
		@(posedge aclk);
		rx_pkt_detect <= 1'b1;
		@(posedge aclk);
		rx_pkt_detect <= 1'b0;
		rx_pkt_end <= 1'b1;
		@(posedge aclk);
		rx_pkt_end <= 1'b0;
		wait_lvl(rx_end_irq, 1'b1, "receive end");
		wr(`IDX_RETRY_COUNT, 8'h02);
		wr(`IDX_RETRY_ACK, 8'h4A);
		run_frame(1'b0, 4'h0, 1'b1, 3, 1, "burst");
		wr(`IDX_RETRY_COUNT, 8'h00);
		run_frame(1'b0, 4'h0, 1'b1, 1, 1, "single");
		wr(`IDX_RETRY_COUNT, 8'h12);
		wr(`IDX_RETRY_ACK, 8'hD2);
		run_frame(1'b1, 4'h0, 1'b0, 3, 3, "no ack");
		run_frame(1'b1, 4'h2, 1'b0, 2, 2, "ack second");
		// Last-only interrupt in ack mode: one pulse when the ack ends the frame
		wr(`IDX_RETRY_COUNT, 8'h02);
		run_frame(1'b1, 4'h2, 1'b0, 2, 1, "ack last irq");
		wr(`IDX_RETRY_COUNT, 8'h12);
		wr(`IDX_RETRY_ACK, 8'hC2);
		run_frame(1'b1, 4'h0, 1'b1, 3, 3, "ack off");
		end_of_test();
	end
endmodule
`default_nettype wire
